// ===== hdl/gpg_cfg.svh
// Register offsets, field positions and reset values of the port
`ifndef GPG_CFG_SVH
`define GPG_CFG_SVH
// Byte offsets on the register bus
`define GPG_OFF_PIN_DIR 12'h000
`define GPG_OFF_LATCH 12'h004
`define GPG_OFF_DRIVE 12'h008
`define GPG_OFF_ROUTE 12'h00C
// Routing select bit positions
`define GPG_RT_B1 3
`define GPG_RT_B0 2
`define GPG_RT_A1 1
`define GPG_RT_A0 0
// Pin numbers of the shared bus pins
`define GPG_PIN_B_CLK 7
`define GPG_PIN_B_DAT 6
`define GPG_PIN_A_CLK 5
`define GPG_PIN_A_DAT 4
// Reset values
`define GPG_RST_DIR 8'h00
`define GPG_RST_LATCH 8'h00
`define GPG_RST_DRIVE 8'h00
`define GPG_RST_ROUTE 4'h0
`endif

// ===== hdl/gpg_pkg.sv
// Types shared by the port and its bench
package gpg_pkg;
    // Low-drive requests from one serial bus controller
    typedef struct packed {
        logic clk_low;
        logic data_low;
    } gpg_bus_drv_t;
    // Line levels handed back to one serial bus controller
    typedef struct packed {
        logic clk_lvl;
        logic data_lvl;
    } gpg_bus_lvl_t;
endpackage

// ===== hdl/gpg_port.sv
// Eight-bit general purpose port with two shared serial bus pin pairs
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "gpg_cfg.svh"

// Functional notes
// (R1) Per-pin direction bit, 1 output, reset 0
// (R2) Direction write-only, shared address reads pins
// (R3) Shared address write updates direction only
// (R4) Output latch always read/write, reset zero
// (R5) Pin level read returns live pins
// (R6) Plain output driven from latch bit
// (R7) Bus-B select moves pins 7,6 to bus
// (R8) Bus-A select moves pins 5,4 to bus
// (R9) Bus pins open drain, never driven high
// (R10) Pins 3..0 plain input or output
// (R11) Drive-type bit: 1 disables high drive
module gpg_port
    import gpg_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    // Clock, reset and freeze
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Package pins
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    // Serial bus controllers
    input wire gpg_bus_drv_t bus_a_drv,
    input wire gpg_bus_drv_t bus_b_drv,
    output gpg_bus_lvl_t bus_a_lvl,
    output gpg_bus_lvl_t bus_b_lvl
);

    // Control registers
    logic [PIN_COUNT-1:0] port_direction_reg; // Direction per pin
    logic [PIN_COUNT-1:0] port_output_latch; // Output data
    logic [PIN_COUNT-1:0] port_drive_type_reg; // 1 selects open drain
    logic [3:0] bus_routing_control_reg; // Bus routing selects

    // Pin synchroniser stages
    logic [PIN_COUNT-1:0] pin_meta; // First stage, read by second only
    logic [PIN_COUNT-1:0] port_pin_level_reg; // Second stage, live levels

    // Bus decode
    logic acc_start; // Access phase, answer not yet given
    logic acc_done; // Access completes at this edge
    logic hit_pin_dir; // Shared level and direction word
    logic hit_latch; // Output latch word
    logic hit_drive; // Drive type word
    logic hit_route; // Routing word
    logic hit_any; // Mapped address
    logic [31:0] next_prdata; // Read mux

    // Pin drive
    logic bus_a_on; // Pins 5,4 belong to bus A
    logic bus_b_on; // Pins 7,6 belong to bus B
    logic [PIN_COUNT-1:0] bus_sel; // Pin handed to a bus
    logic [PIN_COUNT-1:0] bus_low; // Bus asks for low drive
    logic [PIN_COUNT-1:0] next_pin_out; // Next driven level
    logic [PIN_COUNT-1:0] next_pin_oe; // Next enable

    // Address decode and phase tracking
    assign acc_start = psel && penable && !pready;
    assign acc_done = psel && penable && pready;
    assign hit_pin_dir = (paddr == `GPG_OFF_PIN_DIR);
    assign hit_latch = (paddr == `GPG_OFF_LATCH);
    assign hit_drive = (paddr == `GPG_OFF_DRIVE);
    assign hit_route = (paddr == `GPG_OFF_ROUTE);
    assign hit_any = hit_pin_dir || hit_latch || hit_drive || hit_route;

    // Read data mux, unmapped reads give zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_pin_dir) begin
            // Shared word shows pins, never direction
            next_prdata[PIN_COUNT-1:0] = port_pin_level_reg; // R2 R5
        end else if (hit_latch) begin
            next_prdata[PIN_COUNT-1:0] = port_output_latch; // R4
        end else if (hit_drive) begin
            next_prdata[PIN_COUNT-1:0] = port_drive_type_reg; // R11
        end else if (hit_route) begin
            next_prdata[3:0] = bus_routing_control_reg;
        end
    end

    // Answer one cycle into the access phase, then drop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (acc_start) begin
                pready <= 1'b1;
                pslverr <= !hit_any;
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Direction, written through the shared address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_direction_reg <= `GPG_RST_DIR; // R1
        end else if (ce && acc_done && pwrite && hit_pin_dir) begin
            // Level word itself has no storage to write
            port_direction_reg <= pwdata[PIN_COUNT-1:0]; // R3
        end
    end

    // Output latch, writable in any direction
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_output_latch <= `GPG_RST_LATCH; // R4
        end else if (ce && acc_done && pwrite && hit_latch) begin
            port_output_latch <= pwdata[PIN_COUNT-1:0]; // R4
        end
    end

    // Drive type per pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_drive_type_reg <= `GPG_RST_DRIVE; // R11
        end else if (ce && acc_done && pwrite && hit_drive) begin
            port_drive_type_reg <= pwdata[PIN_COUNT-1:0]; // R11
        end
    end

    // Routing selects for the two bus pin pairs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_routing_control_reg <= `GPG_RST_ROUTE;
        end else if (ce && acc_done && pwrite && hit_route) begin
            bus_routing_control_reg <= pwdata[3:0];
        end
    end

    // Two-stage pin synchroniser
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            port_pin_level_reg <= '0;
        end else if (ce) begin
            pin_meta <= pin_in;
            port_pin_level_reg <= pin_meta; // R5
        end
    end

    // Either select bit of a pair hands the pins over
    assign bus_b_on = bus_routing_control_reg[`GPG_RT_B1]
        || bus_routing_control_reg[`GPG_RT_B0]; // R7
    assign bus_a_on = bus_routing_control_reg[`GPG_RT_A1]
        || bus_routing_control_reg[`GPG_RT_A0]; // R8

    // Per-pin bus ownership and low-drive request
    always_comb begin
        bus_sel = '0;
        bus_low = '0;
        bus_sel[`GPG_PIN_B_CLK] = bus_b_on; // R7
        bus_sel[`GPG_PIN_B_DAT] = bus_b_on; // R7
        bus_sel[`GPG_PIN_A_CLK] = bus_a_on; // R8
        bus_sel[`GPG_PIN_A_DAT] = bus_a_on; // R8
        bus_low[`GPG_PIN_B_CLK] = bus_b_drv.clk_low;
        bus_low[`GPG_PIN_B_DAT] = bus_b_drv.data_low;
        bus_low[`GPG_PIN_A_CLK] = bus_a_drv.clk_low;
        bus_low[`GPG_PIN_A_DAT] = bus_a_drv.data_low;
    end

    // Drive selection, one copy per pin
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        always_comb begin
            if (bus_sel[i]) begin
                // Open drain, only ever pulls low
                next_pin_out[i] = 1'b0; // R9
                next_pin_oe[i] = bus_low[i]; // R9
            end else if (!port_direction_reg[i]) begin
                // Input, driver off
                next_pin_out[i] = 1'b0; // R1 R10
                next_pin_oe[i] = 1'b0; // R1 R10
            end else if (port_drive_type_reg[i]) begin
                // Open drain, high side off for a 1
                next_pin_out[i] = 1'b0; // R11
                next_pin_oe[i] = !port_output_latch[i]; // R11
            end else begin
                // Push-pull from the latch
                next_pin_out[i] = port_output_latch[i]; // R6 R10
                next_pin_oe[i] = 1'b1; // R6 R10
            end
        end
    end

    // Registered pin drivers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else if (ce) begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    // Line levels back to the bus controllers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_a_lvl <= '0;
            bus_b_lvl <= '0;
        end else if (ce) begin
            bus_b_lvl.clk_lvl <= port_pin_level_reg[`GPG_PIN_B_CLK];
            bus_b_lvl.data_lvl <= port_pin_level_reg[`GPG_PIN_B_DAT];
            bus_a_lvl.clk_lvl <= port_pin_level_reg[`GPG_PIN_A_CLK];
            bus_a_lvl.data_lvl <= port_pin_level_reg[`GPG_PIN_A_DAT];
        end
    end

    // Checks, all on the system clock
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Inputs everywhere leave every driver off
    chk_inputs_undriven: assert property ( // R1
        ce && port_direction_reg == 8'h00 && bus_routing_control_reg == 4'h0
        |=> pin_oe == 8'h00
    ) else $error("input pin still driven");

    // Shared address read shows pins
    chk_shared_read: assert property ( // R2
        ce && acc_start && !pwrite && hit_pin_dir
        |=> pready && prdata[7:0] == $past(port_pin_level_reg)
    ) else $error("shared read not pin levels");

    // Shared address write lands in direction
    chk_dir_write: assert property ( // R3
        ce && acc_done && pwrite && hit_pin_dir
        |=> port_direction_reg == $past(pwdata[7:0])
    ) else $error("direction not updated");

    // Latch write lands in the latch register
    chk_latch_rw: assert property ( // R4
        ce && acc_done && pwrite && hit_latch
        |=> port_output_latch == $past(pwdata[7:0])
    ) else $error("latch not written");

    // Pin level follows pin after two stages
    chk_pin_sync: assert property ( // R5
        (ce [*3] ##0 !$past(rst, 2)) |-> port_pin_level_reg == $past(pin_in, 2)
    ) else $error("pin level lag wrong");

    // Plain push-pull output on pin 0
    chk_push_pull: assert property ( // R6
        ce && port_direction_reg[0] && !port_drive_type_reg[0]
        |=> pin_oe[0] && pin_out[0] == $past(port_output_latch[0])
    ) else $error("push-pull output wrong");

    // Bus B owns pins 7,6
    chk_bus_b_route: assert property ( // R7
        ce && bus_b_on
        |=> pin_oe[7:6] == $past({bus_b_drv.clk_low, bus_b_drv.data_low})
    ) else $error("bus B pins misrouted");

    // Bus A owns pins 5,4
    chk_bus_a_route: assert property ( // R8
        ce && bus_a_on
        |=> pin_oe[5:4] == $past({bus_a_drv.clk_low, bus_a_drv.data_low})
    ) else $error("bus A pins misrouted");

    // Bus pins never driven high
    chk_bus_no_high: assert property ( // R9
        ce && (bus_a_on || bus_b_on)
        |=> (pin_out & $past(bus_sel)) == 8'h00
    ) else $error("bus pin driven high");

    // Pin 3 plain input when direction clear
    chk_low_input: assert property ( // R10
        ce && !port_direction_reg[3] |=> !pin_oe[3]
    ) else $error("pin 3 driven as input");

    // Open drain with latch 1 releases pin 2
    chk_open_drain: assert property ( // R11
        ce && port_direction_reg[2] && port_drive_type_reg[2]
        |=> pin_oe[2] == !$past(port_output_latch[2]) && !pin_out[2]
    ) else $error("open drain drive wrong");

endmodule

// ===== tb/gpg_pin_model.sv
// Board model: pin wires with pull-ups and external drivers
`timescale 1ns/1ps
module gpg_pin_model (
    // Port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Outside drivers, set by the bench
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved wire levels
    output logic [7:0] pin_in
);
    // Port drive wins, then outside drive, else the pull-up holds high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else begin
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule

// ===== tb/gpg_port_tb_top.sv
// Self-checking bench for the eight-bit port
`timescale 1ns/1ps
`include "gpg_cfg.svh"
module gpg_port_tb_top;
    import gpg_pkg::*;
    logic sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] pin_out, pin_oe, pin_in, ext_en, ext_val;
    gpg_bus_drv_t bus_a_drv, bus_b_drv;
    gpg_bus_lvl_t bus_a_lvl, bus_b_lvl;
    int bad_count = 0;
    int total_checks = 0;
    logic err;
    // Device under test
    gpg_port i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .bus_a_drv(bus_a_drv), .bus_b_drv(bus_b_drv), .bus_a_lvl(bus_a_lvl),
        .bus_b_lvl(bus_b_lvl));
    // Board wires
    gpg_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));
    // Clock, 25 ns period
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h1, "no pready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Let pin drive, synchronisers and bus level register settle
    task automatic settle();
        repeat (5) @(posedge sys_clk);
    endtask
    // Reset state of registers and pins
    task automatic t_reset();
        chk({24'h0, pin_oe}, 32'h0, "oe after reset");
        apb(1'b0, `GPG_OFF_LATCH, 32'h0);
        chk(rd, 32'h0, "latch reset");
        apb(1'b0, `GPG_OFF_DRIVE, 32'h0);
        chk(rd, 32'h0, "drive reset");
    endtask
    // Direction write-only, shared address reads live pins
    task automatic t_dir();
        ext_en <= 8'hF0;
        ext_val <= 8'hA0;
        apb(1'b1, `GPG_OFF_LATCH, 32'h0000005A);
        apb(1'b0, `GPG_OFF_LATCH, 32'h0);
        chk(rd, 32'h5A, "latch readback, inputs");
        apb(1'b1, `GPG_OFF_PIN_DIR, 32'h0000000F);
        settle();
        chk({16'h0, pin_oe, pin_out}, 32'h0F0A, "low pins output");
        apb(1'b0, `GPG_OFF_PIN_DIR, 32'h0);
        chk(rd, 32'hAA, "shared address reads pins");
        ext_val <= 8'h50;
        settle();
        apb(1'b0, `GPG_OFF_PIN_DIR, 32'h0);
        chk(rd, 32'h5A, "pin levels follow wires");
        apb(1'b1, `GPG_OFF_PIN_DIR, 32'h000000FF);
        ext_en <= 8'h00;
        settle();
        chk({16'h0, pin_oe, pin_out}, 32'hFF5A, "push-pull outputs");
    endtask
    // Open drain: high drive off where latch holds 1
    task automatic t_drive();
        apb(1'b1, `GPG_OFF_DRIVE, 32'h000000FF);
        apb(1'b0, `GPG_OFF_DRIVE, 32'h0);
        chk(rd, 32'hFF, "drive readback");
        settle();
        chk({16'h0, pin_oe, pin_out}, 32'hA500, "open drain");
        apb(1'b1, `GPG_OFF_DRIVE, 32'h0);
        apb(1'b1, `GPG_OFF_LATCH, 32'h000000FF);
    endtask
    // Each routing bit hands its pin pair to a bus controller
    task automatic t_route();
        int hi;
        for (int k = 0; k < 4; k++) begin
            hi = (k >= 2) ? 7 : 5;
            apb(1'b1, `GPG_OFF_ROUTE, 32'h1 << k);
            bus_a_drv <= '{clk_low: 1'b1, data_low: 1'b0};
            bus_b_drv <= '{clk_low: 1'b1, data_low: 1'b0};
            ext_en[hi-1] <= 1'b1;
            ext_val[hi-1] <= 1'b0;
            settle();
            chk({30'h0, pin_oe[hi], pin_oe[hi-1]}, 32'h2, "bus pin enables");
            chk({30'h0, pin_out[hi], pin_out[hi-1]}, 32'h0, "bus never high");
            chk({24'h0, (pin_oe ^ pin_out) & ~(8'h03 << (hi-1))}, 32'h0, "unrouted pins");
            chk({30'h0, (k >= 2) ? bus_b_lvl : bus_a_lvl}, 32'h0, "bus levels low");
            bus_a_drv <= '0;
            bus_b_drv <= '0;
            ext_en <= 8'h00;
            settle();
            chk({30'h0, (k >= 2) ? bus_b_lvl : bus_a_lvl}, 32'h3, "bus released");
        end
        apb(1'b1, `GPG_OFF_ROUTE, 32'h0);
        settle();
        chk({24'h0, pin_oe}, 32'hFF, "pins back to port");
    endtask
    // Unmapped address refused
    task automatic t_unmapped();
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1, "write error");
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1, "read error");
        chk(rd, 32'h0, "read data zero");
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_en = 8'h00;
        ext_val = 8'h00;
        bus_a_drv = '0;
        bus_b_drv = '0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_dir();
        t_drive();
        t_route();
        t_unmapped();
        summarize();
    end
    // Watchdog
    initial begin
        #(25 * 20000);
        bad_count++;
        summarize();
    end
endmodule
